// file: uefs_ep_fifo.sv
// one endpoint byte fifo whose capacity follows a two-bit size code
`timescale 1ns/1ps
module uefs_ep_fifo
    import uefs_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [1:0] size_code,
    input  wire logic       flush,
    input  wire logic       wr_valid,
    output logic            wr_ready,
    input  wire logic [7:0] wr_data,
    output logic            rd_valid,
    input  wire logic       rd_ready,
    output logic [7:0]      rd_data,
    output logic [6:0]      level
);
    import uefs_pkg::*;

    typedef struct packed {
        logic [UEFS_PTR_W-1:0] wp;   // write pointer
        logic [UEFS_PTR_W-1:0] rp;   // read pointer
        logic [6:0]            cnt;  // bytes held
    } uefs_fifo_type;

    uefs_fifo_type st_r;             // registered state
    uefs_fifo_type st_nxt;           // next state
    logic [7:0]    mem [DEPTH];      // byte storage
    logic [6:0]    cap;              // live capacity
    logic          do_wr;            // byte accepted
    logic          do_rd;            // byte drained
    logic [UEFS_PTR_W-1:0] wrap;     // pointer mask for capacity

    // capacity from size code; pointers wrap inside it
    assign cap      = uefs_cap(size_code);
    assign wrap     = UEFS_PTR_W'(cap - 7'h01);
    // a shrink below the held count simply stalls writes until drained
    assign wr_ready = (st_r.cnt < cap);
    assign rd_valid = (st_r.cnt != 7'h00);
    assign do_wr    = wr_valid && wr_ready && !flush;
    assign do_rd    = rd_valid && rd_ready && !flush;
    assign rd_data  = mem[st_r.rp];
    assign level    = st_r.cnt;

    // next state of pointers and count
    always_comb begin
        st_nxt = st_r;
        if (flush) begin
            st_nxt = '0;
        end else begin
            if (do_wr) begin
                st_nxt.wp = (st_r.wp + 1'b1) & wrap;
            end
            if (do_rd) begin
                st_nxt.rp = (st_r.rp + 1'b1) & wrap;
            end
            st_nxt.cnt = st_r.cnt + {6'h00, do_wr} - {6'h00, do_rd};
        end
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage has no reset: contents are meaningless until written
    always_ff @(posedge aclk) begin
        if (do_wr) begin
            mem[st_r.wp] <= wr_data;
        end
    end

endmodule

// file: uefs_pkg.sv
// package: register map, field layout and constants of the endpoint fifo bank
package uefs_pkg;

    // register byte offsets on the axi4-lite bus
    localparam logic [7:0] UEFS_OFF_SIZE_LOW  = 8'h00;
    localparam logic [7:0] UEFS_OFF_SIZE_HIGH = 8'h04;
    localparam logic [7:0] UEFS_OFF_REDEF     = 8'h08;
    localparam logic [7:0] UEFS_OFF_STATUS    = 8'h0c;
    localparam logic [7:0] UEFS_OFF_PORT_BASE = 8'h20;

    // field positions: size code of endpoint n sits at bit 2*(n mod 4)
    localparam int UEFS_EP1_POS = 2;
    localparam int UEFS_EP2_POS = 4;
    localparam int UEFS_EP3_POS = 6;
    localparam int UEFS_EP4_POS = 0;
    localparam int UEFS_EP5_POS = 2;
    localparam int UEFS_EP6_POS = 4;
    localparam int UEFS_EP7_POS = 6;

    // reset values
    localparam logic [7:0] UEFS_SIZE_LOW_RST  = 8'h00;
    localparam logic [7:0] UEFS_SIZE_HIGH_RST = 8'h00;

    // implemented bits of each size register
    localparam logic [7:0] UEFS_LOW_MASK      = 8'hfc;
    localparam logic [7:0] UEFS_HIGH_MASK_8EP = 8'hff;
    localparam logic [7:0] UEFS_HIGH_MASK_6EP = 8'h0f;

    // size codes
    localparam logic [1:0] UEFS_SZ_8  = 2'h0;
    localparam logic [1:0] UEFS_SZ_16 = 2'h1;
    localparam logic [1:0] UEFS_SZ_32 = 2'h2;
    localparam logic [1:0] UEFS_SZ_64 = 2'h3;

    // largest buffer, in bytes and address bits
    localparam int UEFS_MAX_BYTES = 64;
    localparam int UEFS_PTR_W     = 6;

    // axi responses
    localparam logic [1:0] UEFS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] UEFS_RESP_SLVERR = 2'h2;

    // code to capacity in bytes
    function automatic logic [6:0] uefs_cap(input logic [1:0] code);
        unique case (code)
            UEFS_SZ_8:  uefs_cap = 7'h08;
            UEFS_SZ_16: uefs_cap = 7'h10;
            UEFS_SZ_32: uefs_cap = 7'h20;
            UEFS_SZ_64: uefs_cap = 7'h40;
        endcase
    endfunction

endpackage

// file: uefs_sie_model.sv
// behavioural serial interface engine on the far side of the fifos
`timescale 1ns/1ps
module uefs_sie_model #(
    parameter int NUM_EP = 8
) (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                stall,
    output logic [NUM_EP-1:0]       sie_in_valid,
    input wire logic [NUM_EP-1:0]   sie_in_ready,
    output logic [NUM_EP*8-1:0]     sie_in_data,
    input wire logic [NUM_EP-1:0]   sie_out_valid,
    output logic [NUM_EP-1:0]       sie_out_ready,
    input wire logic [NUM_EP*8-1:0] sie_out_data
);
    int         rx_cnt [NUM_EP];   // bytes drained per endpoint
    int         rx_total;          // bytes drained overall
    int         order_err;         // bytes out of sequence
    logic [7:0] next_exp [NUM_EP]; // next byte expected per endpoint
    initial begin
        sie_in_valid = '0;
        sie_in_data  = '0;
    end
    // stalling holds every endpoint back, so fills reach full
    assign sie_out_ready = stall ? '0 : '1;
    ////////////////////////////////////////////////////////////////////
    // drain side: each endpoint must deliver 0,1,2.. in order
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_total  <= 0;
            order_err <= 0;
            for (int e = 0; e < NUM_EP; e++) begin
                rx_cnt[e]   <= 0;
                next_exp[e] <= 8'h00;
            end
        end else begin
            rx_total <= rx_total + $countones(sie_out_valid & sie_out_ready);
            for (int e = 0; e < NUM_EP; e++) begin
                if (sie_out_valid[e] && sie_out_ready[e]) begin
                    if (sie_out_data[e*8+:8] !== next_exp[e]) begin
                        order_err <= order_err + 1;
                    end
                    next_exp[e] <= next_exp[e] + 8'h01;
                    rx_cnt[e]   <= rx_cnt[e] + 1;
                end
            end
        end
    end
    // offer one byte to the cpu side, held until taken or 50 cycles pass
    task automatic send(input int ep, input logic [7:0] b);
        @(posedge aclk);
        sie_in_valid[ep]     <= 1'b1;
        sie_in_data[ep*8+:8] <= b;
        repeat (50) begin
            @(posedge aclk);
            if (sie_in_ready[ep]) break;
        end
        // released line shows the inverse, never a stale copy
        sie_in_valid[ep]     <= 1'b0;
        sie_in_data[ep*8+:8] <= ~b;
    endtask
endmodule

// file: uefs_top.sv
// endpoint fifo sizing registers, data ports and axi4-lite slave
`timescale 1ns/1ps

// What this block does
// - size code selects 8, 16, 32, 64 bytes
// - low register: ep3, ep2, ep1 size fields
// - low register bits 1:0 read zero
// - eight-endpoint variant: high register ep7..ep4
// - six-endpoint variant: high bits 7:4 zero
// - redefine bit applies config, then self-clears
module uefs_top
    import uefs_pkg::*;
#(
    parameter int NUM_EP = 8
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [NUM_EP-1:0]      sie_in_valid,
    output logic [NUM_EP-1:0]           sie_in_ready,
    input  wire logic [NUM_EP*8-1:0]    sie_in_data,
    output logic [NUM_EP-1:0]           sie_out_valid,
    input  wire logic [NUM_EP-1:0]      sie_out_ready,
    output logic [NUM_EP*8-1:0]         sie_out_data,
    output logic [NUM_EP*2-1:0]         sie_size_code,
    output logic                        sie_redefine
);
    import uefs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic        aw_hold;   // write address captured
        logic [7:0]  aw_addr;   // captured write address
        logic        w_hold;    // write data captured
        logic [31:0] w_data;    // captured write data
        logic [3:0]  w_strb;    // captured strobes
        logic        bvalid;    // write response pending
        logic [1:0]  bresp;     // write response code
        logic        rvalid;    // read data pending
        logic [1:0]  rresp;     // read response code
        logic [31:0] rdata;     // read data
        logic [7:0]  size_low;  // endpoint 1..3 sizes
        logic [7:0]  size_high; // endpoint 4..7 sizes
        logic        redef;     // redefine request bit
        logic [NUM_EP*2-1:0] size_live; // codes applied to fifos
    } uefs_state_type;

    uefs_state_type st_r;       // registered state
    uefs_state_type st_nxt;     // next state

    localparam logic [7:0] HIGH_MASK =
        (NUM_EP > 6) ? UEFS_HIGH_MASK_8EP : UEFS_HIGH_MASK_6EP;

    // per-endpoint processor side of each fifo
    logic [NUM_EP-1:0]   cpu_wr;      // cpu pushes a byte
    logic [NUM_EP-1:0]   cpu_rd;      // cpu pops a byte
    logic [NUM_EP-1:0]   up_ready;    // fifo toward sie has room
    logic [NUM_EP-1:0]   dn_valid;    // fifo from sie has a byte
    logic [NUM_EP*8-1:0] dn_data;     // byte at head from sie

    // bus handshakes
    logic        wr_fire;    // both halves of a write present
    logic        rd_fire;    // read address taken
    logic [7:0]  wa;         // effective write address
    logic [31:0] wd;         // effective write data
    logic [3:0]  ws;         // effective strobes

    ////////////////////////////////////////////////////////////////////////
    // address decode helpers

    // index of a data port address, or NUM_EP when not a port
    function automatic int port_idx(input logic [7:0] a);
        port_idx = NUM_EP;
        for (int i = 0; i < NUM_EP; i++) begin
            if (a == UEFS_OFF_PORT_BASE + 8'(i * 4)) begin
                port_idx = i;
            end
        end
    endfunction

    // size code of endpoint n out of the size registers (endpoint 0 fixed)
    function automatic logic [1:0] ep_code(input logic [7:0] lo,
                                           input logic [7:0] hi,
                                           input int n);
        logic [15:0] both;
        both = {hi, lo};
        if (n == 0) begin
            ep_code = UEFS_SZ_8;
        end else begin
            ep_code = both[n*2 +: 2];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // axi channel outputs

    // address and data are each taken once and held until the response
    assign s_axi_awready = !st_r.aw_hold && !st_r.bvalid;
    assign s_axi_wready  = !st_r.w_hold && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rresp   = st_r.rresp;
    assign s_axi_rdata   = st_r.rdata;
    assign sie_size_code = st_r.size_live;
    assign sie_redefine  = st_r.redef;

    assign wa = st_r.aw_hold ? st_r.aw_addr : s_axi_awaddr;
    assign wd = st_r.w_hold ? st_r.w_data : s_axi_wdata;
    assign ws = st_r.w_hold ? st_r.w_strb : s_axi_wstrb;
    assign wr_fire = (st_r.aw_hold || (s_axi_awvalid && s_axi_awready))
                  && (st_r.w_hold || (s_axi_wvalid && s_axi_wready));
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    ////////////////////////////////////////////////////////////////////////
    // data port strobes: one byte moves per bus access

    always_comb begin
        cpu_wr = '0;
        cpu_rd = '0;
        for (int i = 0; i < NUM_EP; i++) begin
            // write lands only with lane 0 and room in the fifo
            if (wr_fire && port_idx(wa) == i && ws[0] && up_ready[i]) begin
                cpu_wr[i] = 1'b1;
            end
            if (rd_fire && port_idx(s_axi_araddr) == i && dn_valid[i]) begin
                cpu_rd[i] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of the register bank and bus slave

    always_comb begin
        int pi;
        int pr;
        st_nxt = st_r;
        pi = port_idx(wa);
        pr = port_idx(s_axi_araddr);

        // capture halves that arrive alone
        if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
            st_nxt.aw_hold = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
            st_nxt.w_hold = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end

        // the live sizes take the new codes and the bit drops at the same edge
        if (st_r.redef) begin
            for (int n = 0; n < NUM_EP; n++) begin
                st_nxt.size_live[n*2 +: 2] =
                    ep_code(st_r.size_low, st_r.size_high, n);
            end
            st_nxt.redef = 1'b0;
        end

        // write: decode and commit
        if (wr_fire) begin
            st_nxt.aw_hold = 1'b0;
            st_nxt.w_hold  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = UEFS_RESP_OKAY;
            if (wa == UEFS_OFF_SIZE_LOW) begin
                if (ws[0]) begin
                    st_nxt.size_low = wd[7:0] & UEFS_LOW_MASK;
                end
            end else if (wa == UEFS_OFF_SIZE_HIGH) begin
                if (ws[0]) begin
                    st_nxt.size_high = wd[7:0] & HIGH_MASK;
                end
            end else if (wa == UEFS_OFF_REDEF) begin
                // a new request wins over the self-clear of the same cycle
                if (ws[0] && wd[0]) begin
                    st_nxt.redef = 1'b1;
                end
            end else if (wa == UEFS_OFF_STATUS) begin
                st_nxt.bresp = UEFS_RESP_OKAY;
            end else if (pi < NUM_EP) begin
                // full fifo drops the byte and reports it
                if (!up_ready[pi]) begin
                    st_nxt.bresp = UEFS_RESP_SLVERR;
                end
            end else begin
                st_nxt.bresp = UEFS_RESP_SLVERR;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // read: decode into a registered answer
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (rd_fire) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = UEFS_RESP_OKAY;
            st_nxt.rdata  = 32'h0000_0000;
            if (s_axi_araddr == UEFS_OFF_SIZE_LOW) begin
                st_nxt.rdata[7:0] = st_r.size_low;
            end else if (s_axi_araddr == UEFS_OFF_SIZE_HIGH) begin
                st_nxt.rdata[7:0] = st_r.size_high;
            end else if (s_axi_araddr == UEFS_OFF_REDEF) begin
                st_nxt.rdata[0] = st_r.redef;
            end else if (s_axi_araddr == UEFS_OFF_STATUS) begin
                st_nxt.rdata[NUM_EP-1:0]      = dn_valid;
                st_nxt.rdata[NUM_EP+15:16]    = up_ready;
            end else if (pr < NUM_EP) begin
                if (dn_valid[pr]) begin
                    st_nxt.rdata[7:0] = dn_data[pr*8 +: 8];
                end else begin
                    st_nxt.rresp = UEFS_RESP_SLVERR;
                end
            end else begin
                st_nxt.rresp = UEFS_RESP_SLVERR;
            end
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r           <= '0;
            st_r.size_low  <= UEFS_SIZE_LOW_RST;
            st_r.size_high <= UEFS_SIZE_HIGH_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two fifos per endpoint: cpu to sie and sie to cpu

    // request and direction flags are kept by firmware around these
    // accesses; the ports only ever move one byte per access
    for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
        uefs_ep_fifo #(.DEPTH(UEFS_MAX_BYTES)) u_up (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .size_code (st_r.size_live[g*2 +: 2]),
            .flush     (st_r.redef),
            .wr_valid  (cpu_wr[g]),
            .wr_ready  (up_ready[g]),
            .wr_data   (wd[7:0]),
            .rd_valid  (sie_out_valid[g]),
            .rd_ready  (sie_out_ready[g]),
            .rd_data   (sie_out_data[g*8 +: 8]),
            .level     ()
        );
        uefs_ep_fifo #(.DEPTH(UEFS_MAX_BYTES)) u_dn (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .size_code (st_r.size_live[g*2 +: 2]),
            .flush     (st_r.redef),
            .wr_valid  (sie_in_valid[g]),
            .wr_ready  (sie_in_ready[g]),
            .wr_data   (sie_in_data[g*8 +: 8]),
            .rd_valid  (dn_valid[g]),
            .rd_ready  (cpu_rd[g]),
            .rd_data   (dn_data[g*8 +: 8]),
            .level     ()
        );
    end

endmodule

// file: uefs_top_monitor.sv
// checker watching the bus and sie ports of the endpoint fifo bank
`timescale 1ns/1ps
module uefs_top_monitor
    import uefs_pkg::*;
#(
    parameter int NUM_EP = 8
) (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic [7:0]          s_axi_awaddr,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic [31:0]         s_axi_wdata,
    input wire logic [3:0]          s_axi_wstrb,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic [7:0]          s_axi_araddr,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic [1:0]          s_axi_rresp,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire logic [NUM_EP*2-1:0] sie_size_code,
    input wire logic                sie_redefine
);
    // six-endpoint parts leave the top half of the high register empty
    localparam logic [7:0] HMASK = (NUM_EP == 8) ? UEFS_HIGH_MASK_8EP
                                                 : UEFS_HIGH_MASK_6EP;
    logic wr_both; // both write halves taken at one edge
    logic ar_hit;  // read address taken
    assign wr_both = s_axi_awvalid && s_axi_awready
                     && s_axi_wvalid && s_axi_wready;
    assign ar_hit  = s_axi_arvalid && s_axi_arready;
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (wr_both |=> s_axi_bvalid)
        else $error("write response missing");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (ar_hit |=> s_axi_rvalid)
        else $error("read data missing");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)
            && $stable(s_axi_rresp))
        else $error("read data changed while waiting");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while one pending");
    a_low_unimpl: assert property (ar_hit
        && s_axi_araddr == UEFS_OFF_SIZE_LOW |=> s_axi_rdata[1:0] == 2'h0
        && s_axi_rdata[31:8] == 24'h0)
        else $error("low register spare bits not zero");
    a_high_mask: assert property (ar_hit
        && s_axi_araddr == UEFS_OFF_SIZE_HIGH
        |=> (s_axi_rdata[7:0] & ~HMASK) == 8'h00
        && s_axi_rdata[31:8] == 24'h0)
        else $error("high register unimplemented bits set");
    a_redef_starts: assert property (wr_both
        && s_axi_awaddr == UEFS_OFF_REDEF && s_axi_wdata[0]
        && s_axi_wstrb[0] |=> sie_redefine)
        else $error("redefine did not follow its write");
    a_redef_clears: assert property (sie_redefine && !wr_both
        |=> !sie_redefine)
        else $error("redefine did not self clear");
    a_size_holds: assert property (!sie_redefine
        |=> $stable(sie_size_code))
        else $error("live sizes changed without redefine");
    a_ep0_fixed: assert property (sie_size_code[1:0] == UEFS_SZ_8)
        else $error("endpoint zero not at smallest size");
    c_redef: cover property (sie_redefine);
    c_slverr: cover property (s_axi_rvalid
        && s_axi_rresp == UEFS_RESP_SLVERR);
    c_wr_wait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule

// file: usb_endpoint_fifo_sizing_bench.sv
// self-checking bench for the endpoint fifo sizing bank
`timescale 1ns/1ps
module usb_endpoint_fifo_sizing_bench;
    import uefs_pkg::*;
    localparam int NUM_EP = 8;
    localparam logic [1:0] rsp_ok  = UEFS_RESP_OKAY;
    localparam logic [1:0] rsp_err = UEFS_RESP_SLVERR;
    typedef struct {
        bit          wr;
        logic [7:0]  a;
        logic [31:0] wd;
        logic [31:0] ed;
        logic [1:0]  er;
    } uefs_row_type;
    logic                aclk          = 1'b0;
    logic                aresetn       = 1'b0;
    logic [7:0]          s_axi_awaddr  = 8'h00;
    logic [7:0]          s_axi_araddr  = 8'h00;
    logic [31:0]         s_axi_wdata   = 32'h0;
    logic [3:0]          s_axi_wstrb   = 4'hf;
    logic                s_axi_awvalid = 1'b0;
    logic                s_axi_wvalid  = 1'b0;
    logic                s_axi_bready  = 1'b0;
    logic                s_axi_arvalid = 1'b0;
    logic                s_axi_rready  = 1'b0;
    logic                stall         = 1'b1;
    logic                s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic                s_axi_arready, s_axi_rvalid;
    logic [1:0]          s_axi_bresp, s_axi_rresp;
    logic [31:0]         s_axi_rdata;
    logic [NUM_EP-1:0]   sie_in_valid, sie_in_ready;
    logic [NUM_EP-1:0]   sie_out_valid, sie_out_ready;
    logic [NUM_EP*8-1:0] sie_in_data, sie_out_data;
    logic [NUM_EP*2-1:0] sie_size_code;
    logic                sie_redefine;
    int                  failures = 0;
    int                  compares = 0;
    int                  cycles   = 0;
    int                  caps [4] = '{8, 64, 32, 16}; // ep0..ep3 after redefine
    uefs_row_type rows [14] = '{
        '{1'b0, UEFS_OFF_SIZE_LOW,  32'h0,  32'h00, rsp_ok},
        '{1'b0, UEFS_OFF_SIZE_HIGH, 32'h0,  32'h00, rsp_ok},
        '{1'b1, UEFS_OFF_SIZE_LOW,  32'hff, 32'h00, rsp_ok},
        '{1'b0, UEFS_OFF_SIZE_LOW,  32'h0,  32'hfc, rsp_ok},
        '{1'b1, UEFS_OFF_SIZE_HIGH, 32'hff, 32'h00, rsp_ok},
        '{1'b0, UEFS_OFF_SIZE_HIGH, 32'h0,  32'hff, rsp_ok},
        '{1'b1, UEFS_OFF_SIZE_LOW,  32'h6c, 32'h00, rsp_ok},
        '{1'b1, UEFS_OFF_SIZE_HIGH, 32'h1b, 32'h00, rsp_ok},
        '{1'b0, UEFS_OFF_SIZE_LOW,  32'h0,  32'h6c, rsp_ok},
        '{1'b0, UEFS_OFF_SIZE_HIGH, 32'h0,  32'h1b, rsp_ok},
        '{1'b0, UEFS_OFF_STATUS, 32'h0, 32'h00ff0000, rsp_ok},
        '{1'b0, 8'h10,              32'h0,  32'h00, rsp_err},
        '{1'b1, 8'h14,              32'h1,  32'h00, rsp_err},
        '{1'b1, UEFS_OFF_REDEF,     32'h1,  32'h00, rsp_ok}};
    uefs_top #(.NUM_EP(NUM_EP)) u_dut (.*);
    uefs_sie_model #(.NUM_EP(NUM_EP)) u_sie (.*);
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 aclk = ~aclk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one bus access; ready for the answer stands from the request on
    task automatic axi(input bit wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic [1:0] rs);
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr  <= a;
            s_axi_wdata   <= wd;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
        end else begin
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
        end
        repeat (100) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
            if (s_axi_rready && s_axi_rvalid) begin
                rd = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        failures++;
        summarize();
    endtask
    task automatic summarize();
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] rd;
        logic [1:0]  rs;
        int          n;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            axi(rows[i].wr, rows[i].a, rows[i].wd, rd, rs);
            chk({30'h0, rs}, {30'h0, rows[i].er});
            if (!rows[i].wr && rows[i].er === rsp_ok)
                chk(rd, rows[i].ed);
        end
        repeat (2) @(posedge aclk);
        chk({16'h0, sie_size_code}, 32'h1b6c);
        chk({31'h0, sie_redefine}, 32'h0);
        // fill the ep0..ep3 fifos to their size, plus one refused byte, with the far side stalled
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i <= caps[k]; i++) begin
                axi(1'b1, UEFS_OFF_PORT_BASE + 8'(4 * k), 32'(i), rd, rs);
                chk({30'h0, rs}, {30'h0, (i == caps[k]) ? rsp_err : rsp_ok});
            end
        end
        stall <= 1'b0;
        n = 0;
        while (u_sie.rx_total < 120 && n < 1000) begin
            @(posedge aclk);
            n++;
        end
        for (int k = 0; k < 4; k++) chk(32'(u_sie.rx_cnt[k]), 32'(caps[k]));
        chk(32'(u_sie.order_err), 32'h0);
        // far side to cpu on endpoint 5, then one read too many
        for (int i = 0; i < 3; i++) u_sie.send(5, 8'ha0 + 8'(i));
        for (int i = 0; i <= 3; i++) begin
            axi(1'b0, UEFS_OFF_PORT_BASE + 8'h14, 32'h0, rd, rs);
            chk({30'h0, rs}, {30'h0, (i == 3) ? rsp_err : rsp_ok});
            chk(rd, (i == 3) ? 32'h0 : 32'(8'ha0 + 8'(i)));
        end
        // second reset in mid-run brings every size back to zero
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi(1'b0, UEFS_OFF_SIZE_LOW, 32'h0, rd, rs);
        chk(rd, 32'h0);
        chk({16'h0, sie_size_code}, 32'h0);
        summarize();
    end
endmodule
bind uefs_top uefs_top_monitor #(.NUM_EP(NUM_EP)) u_mon (.*);
